// ===== rtl/ucd_consts.vh
// constants for the alpha field character decoder
`ifndef UCD_CONSTS_VH
`define UCD_CONSTS_VH
`define UCD_LEAD_PAIR    8'h80
`define UCD_LEAD_HALF    8'h81
`define UCD_LEAD_FULL    8'h82
`define UCD_PAD_BYTE     8'hFF
`define UCD_HALF_SHIFT   7
`define UCD_FIFO_WIDTH   17
`define UCD_FIFO_DEPTH   32
`define UCD_FIFO_AW      5
`endif

// ===== rtl/ucd_fifo.v
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ucd_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign do_wr       = ce_i & in_valid_i & in_ready_o;
  assign do_rd       = ce_i & out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ucd_fifo
`default_nettype wire

// ===== rtl/ucd_decoder.v
// alpha field decoder: record bytes in, 16-bit code points out
`timescale 1ns/100ps
`default_nettype none
`include "ucd_consts.vh"
module ucd_decoder (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire [7:0]  byte_data_i,
  input  wire        byte_valid_i,
  input  wire        byte_last_i,
  output reg         byte_ready_o,
  output reg  [15:0] char_data_o,
  output reg         char_wide_o,
  output reg         char_valid_o,
  input  wire        char_ready_i,
  output reg         busy_o
);
  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam ST_LEAD  = 6'b000001;
  localparam ST_COUNT = 6'b000010;
  localparam ST_BASEH = 6'b000100;
  localparam ST_BASEL = 6'b001000;
  localparam ST_BODY  = 6'b010000;
  localparam ST_SKIP  = 6'b100000;

  localparam SC_PASS = 2'd0;
  localparam SC_PAIR = 2'd1;
  localparam SC_HALF = 2'd2;
  localparam SC_FULL = 2'd3;

  reg [5:0]  state;
  reg [1:0]  scheme;
  reg [7:0]  remain;
  reg [15:0] base;
  reg [7:0]  high_byte;
  reg        have_high;

  reg [5:0]  next_state;
  reg [1:0]  next_scheme;
  reg [7:0]  next_remain;
  reg [15:0] next_base;
  reg [7:0]  next_high_byte;
  reg        next_have_high;
  reg        push;
  reg [16:0] push_word;

  wire        fifo_in_ready;
  wire [16:0] fifo_out_data;
  wire        fifo_out_valid;
  wire        take;
  wire        out_free;
  wire        pending;

  // byte accepted this cycle
  assign take     = ce_i & byte_valid_i & byte_ready_o;
  assign out_free = ~char_valid_o | char_ready_i;
  assign pending  = fifo_out_valid | char_valid_o;

  // ---------------------------------------------------------------
  // decode of one incoming byte
  // ---------------------------------------------------------------
  always @* begin
    next_state     = state;
    next_scheme    = scheme;
    next_remain    = remain;
    next_base      = base;
    next_high_byte = high_byte;
    next_have_high = have_high;
    push           = 1'b0;
    push_word      = 17'h00000;
    if (take) begin
      case (state)
        ST_LEAD: begin
          if (byte_data_i == `UCD_LEAD_PAIR) begin
            next_scheme    = SC_PAIR;
            next_have_high = 1'b0;
            next_state     = ST_BODY;
          end else if (byte_data_i == `UCD_LEAD_HALF) begin
            next_scheme = SC_HALF;
            next_state  = ST_COUNT;
          end else if (byte_data_i == `UCD_LEAD_FULL) begin
            next_scheme = SC_FULL;
            next_state  = ST_COUNT;
          end else begin
            next_scheme = SC_PASS;
            push        = 1'b1;
            push_word   = {9'h000, byte_data_i};
            next_state  = ST_BODY;
          end
        end
        ST_COUNT: begin
          next_remain = byte_data_i;
          next_state  = ST_BASEH;
        end
        ST_BASEH: begin
          if (scheme == SC_HALF) begin
            next_base  = {1'b0, byte_data_i, 7'h00};
            next_state = (remain == 8'h00) ? ST_SKIP : ST_BODY;
          end else begin
            next_base  = {byte_data_i, 8'h00};
            next_state = ST_BASEL;
          end
        end
        ST_BASEL: begin
          next_base[7:0] = byte_data_i;
          next_state     = (remain == 8'h00) ? ST_SKIP : ST_BODY;
        end
        ST_BODY: begin
          case (scheme)
            SC_PAIR: begin
              if (have_high) begin
                push           = 1'b1;
                push_word      = {1'b1, high_byte, byte_data_i};
                next_have_high = 1'b0;
              end else begin
                next_high_byte = byte_data_i;
                next_have_high = 1'b1;
              end
            end
            SC_HALF, SC_FULL: begin
              // bit 7 picks base plus offset over a default character
              push = 1'b1;
              if (byte_data_i[7]) begin
                push_word = {1'b1, base + {9'h000, byte_data_i[6:0]}};
              end else begin
                push_word = {10'h000, byte_data_i[6:0]};
              end
              next_remain = remain - 8'h01;
              if (remain == 8'h01) begin
                next_state = ST_SKIP;
              end
            end
            default: begin
              push      = 1'b1;
              push_word = {9'h000, byte_data_i};
            end
          endcase
        end
        ST_SKIP: begin
          // bytes beyond the count are consumed and dropped
          next_state = state;
        end
        default: begin
          next_state = ST_LEAD;
        end
      endcase
      // the last byte of a record always returns to the lead state
      if (byte_last_i) begin
        next_state     = ST_LEAD;
        next_have_high = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state        <= ST_LEAD;
      scheme       <= SC_PASS;
      remain       <= 8'h00;
      base         <= 16'h0000;
      high_byte    <= 8'h00;
      have_high    <= 1'b0;
      byte_ready_o <= 1'b0;
      busy_o       <= 1'b0;
    end else if (ce_i) begin
      state        <= next_state;
      scheme       <= next_scheme;
      remain       <= next_remain;
      base         <= next_base;
      high_byte    <= next_high_byte;
      have_high    <= next_have_high;
      // ready drops after every take, so a registered ready never overruns
      byte_ready_o <= fifo_in_ready & ~(push & byte_ready_o) & ~take;
      // busy from the first taken byte until the last character has left
      busy_o       <= take | (next_state != ST_LEAD) | pending;
    end
  end

  // ---------------------------------------------------------------
  // output fifo
  // ---------------------------------------------------------------
  ucd_fifo #(
    .WIDTH (`UCD_FIFO_WIDTH),
    .DEPTH (`UCD_FIFO_DEPTH),
    .AW    (`UCD_FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .in_data_i   (push_word),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (out_free)
  );

  // ---------------------------------------------------------------
  // registered output stage
  // ---------------------------------------------------------------
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      char_data_o  <= 16'h0000;
      char_wide_o  <= 1'b0;
      char_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (out_free) begin
        char_valid_o <= fifo_out_valid;
        if (fifo_out_valid) begin
          char_data_o <= fifo_out_data[15:0];
          char_wide_o <= fifo_out_data[16];
        end
      end
    end
  end
endmodule // ucd_decoder
`default_nettype wire

// ===== sim/ucd_decoder_props.sv
// assertion checker for the alpha field decoder ports
`timescale 1ns/100ps
`default_nettype none
module ucd_decoder_props (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  input wire logic [7:0]  byte_data_i,
  input wire logic        byte_valid_i,
  input wire logic        byte_last_i,
  input wire logic        byte_ready_o,
  input wire logic [15:0] char_data_o,
  input wire logic        char_wide_o,
  input wire logic        char_valid_o,
  input wire logic        char_ready_i,
  input wire logic        busy_o
);
  logic       own;
  logic [7:0] lead, b3, b4, idx;
  wire        take = ce_i && byte_valid_i && byte_ready_o;
  wire [15:0] base = (lead == 8'h81) ? {1'b0, b3, 7'h00} : {b3, b4};
  // own: record began with nothing pending, so every output belongs to it
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      own <= 1'b0;
      idx <= 8'h00;
    end else if (take) begin
      idx <= byte_last_i ? 8'h00 : idx + 8'h01;
      if (idx == 8'h00) begin
        lead <= byte_data_i;
        own  <= !busy_o;
      end
      if (idx == 8'h02)
        b3 <= byte_data_i;
      if (idx == 8'h03)
        b4 <= byte_data_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_stall;
    char_valid_o && !char_ready_i && ce_i;
  endsequence
  sequence s_held;
    char_valid_o && $stable(char_data_o) && $stable(char_wide_o);
  endsequence
  sequence s_frozen;
    $stable(char_data_o) && $stable(char_valid_o) && $stable(char_wide_o)
      && $stable(byte_ready_o) && $stable(busy_o);
  endsequence
  AST_RDY_GAP: assert property (take |=> !byte_ready_o)
    else $error("byte ready not dropped");
  AST_HOLD: assert property (s_stall |=> s_held)
    else $error("char changed while stalled");
  AST_BUSY: assert property (take |=> busy_o)
    else $error("busy missing");
  AST_NARROW: assert property (char_valid_o && !char_wide_o |-> !char_data_o[15:8])
    else $error("narrow char too wide");
  AST_PAIR: assert property (own && lead == 8'h80 && char_valid_o |-> char_wide_o)
    else $error("pair scheme char not wide");
  AST_PASS: assert property (own && (lead < 8'h80 || lead > 8'h82) && char_valid_o |-> !char_wide_o)
    else $error("pass record char wide");
  AST_HALF: assert property (own && lead == 8'h81 && char_valid_o && char_wide_o |-> char_data_o - base <= 16'h007F)
    else $error("half page code out of range");
  AST_FULL: assert property (own && lead == 8'h82 && char_valid_o && char_wide_o |-> char_data_o - base <= 16'h007F)
    else $error("full base code out of range");
  AST_FREEZE: assert property (!ce_i |=> s_frozen)
    else $error("state moved with clock enable low");
endmodule // ucd_decoder_props
bind ucd_decoder ucd_decoder_props u_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .byte_data_i(byte_data_i), .byte_valid_i(byte_valid_i), .byte_last_i(byte_last_i),
  .byte_ready_o(byte_ready_o), .char_data_o(char_data_o), .char_wide_o(char_wide_o),
  .char_valid_o(char_valid_o), .char_ready_i(char_ready_i), .busy_o(busy_o));
`default_nettype wire

// ===== sim/ucd_card_model.sv
// card record store feeding alpha bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module ucd_card_model (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] len_i,
  input  wire logic       ready_i,
  input  wire logic       ce_i,
  output var  logic [7:0] data_o,
  output var  logic       valid_o,
  output var  logic       last_o
);
  logic [7:0] mem [0:63];
  logic [7:0] idx;
  // records hold one scheme, loaded by the bench with only their own len bytes, some with trailing bytes the decoder drops
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
      data_o  <= 8'h00;
    end else if (start_i) begin
      valid_o <= 1'b1;
      data_o  <= mem[0];
      last_o  <= (len_i == 8'h01);
      idx     <= 8'h00;
    end else if (ce_i && valid_o && ready_i) begin
      // a released line flips so a stale byte never looks fresh
      valid_o <= !last_o;
      data_o  <= last_o ? ~data_o : mem[idx + 8'h01];
      last_o  <= (idx + 8'h02 == len_i);
      idx     <= idx + 8'h01;
    end
  end
endmodule // ucd_card_model
`default_nettype wire

// ===== sim/ucs2_alpha_field_decoder_test.sv
// self-checking bench for the alpha field decoder
`timescale 1ns/100ps
`default_nettype none
module ucs2_alpha_field_decoder_test;
  logic        clock_i, sys_rst_i, start, char_ready_i, bv, bl, br, cw, cv, busy, ce;
  logic [7:0]  len, bd;
  logic [15:0] cd;
  logic [16:0] got [$];
  int          fails, samples_checked;
  ucd_card_model u_card (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start),
    .len_i(len), .ready_i(br), .ce_i(ce), .data_o(bd), .valid_o(bv), .last_o(bl));
  ucd_decoder u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .byte_data_i(bd),
    .byte_valid_i(bv), .byte_last_i(bl), .byte_ready_o(br), .char_data_o(cd),
    .char_wide_o(cw), .char_valid_o(cv), .char_ready_i(char_ready_i), .busy_o(busy));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
    if (ce && cv && char_ready_i)
      got.push_back({cw, cd});
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [16:0] g, input logic [16:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic go(input int n);
    got.delete();
    @(posedge clock_i);
    len   <= n[7:0];
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
  endtask
  task automatic wait_chars(input int k);
    int t;
    t = 0;
    while (got.size() < k && t < 2000) begin
      @(posedge clock_i);
      t++;
    end
    if (got.size() < k) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic xfer(input logic [71:0] v, input int n, input logic [99:0] e, input int k);
    for (int i = 0; i < n; i++)
      u_card.mem[i] = v[71-8*i -: 8];
    go(n);
    wait_chars(k);
    repeat (30) @(posedge clock_i);
    cmp({16'h0000, busy}, 17'h00000);
    cmp(17'(got.size()), 17'(k));
    for (int i = 0; i < k; i++)
      cmp(got[i], e[96-20*i -: 17]);
  endtask
  task automatic s_pair;
    xfer(72'h80_1234_ABCD_FFFF_FF_00, 8, 100'h11234_1ABCD_1FFFF_00000_00000, 3);
  endtask
  task automatic s_half;
    xfer(72'h81_05_13_53_95_A6_41_FF_FF, 9, 100'h00053_10995_109A6_00041_109FF, 5);
  endtask
  task automatic s_full;
    xfer(72'h82_05_05_30_2D_82_D3_2D_31, 9, 100'h0002D_10532_10583_0002D_00031, 5);
  endtask
  task automatic s_zero;
    xfer(72'h81_00_13_95_00_00_00_00_00, 4, 100'h0, 0);
  endtask
  task automatic s_fill;
    for (int i = 0; i < 40; i++)
      u_card.mem[i] = 8'h20 + i[7:0];
    char_ready_i <= 1'b0;
    go(40);
    repeat (200) @(posedge clock_i);
    cmp({16'h0000, bv}, 17'h00001);
    cmp({16'h0000, br}, 17'h00000);
    cmp({16'h0000, busy}, 17'h00001);
    char_ready_i <= 1'b1;
    wait_chars(40);
    for (int i = 0; i < 40; i++)
      cmp(got[i], {9'h000, 8'h20 + i[7:0]});
  endtask
  task automatic s_freeze;
    for (int i = 0; i < 9; i++)
      u_card.mem[i] = 8'h50 + i[7:0];
    go(9);
    repeat (6) @(posedge clock_i);
    ce <= 1'b0;
    repeat (20) @(posedge clock_i);
    cmp({16'h0000, busy}, 17'h00001);
    ce <= 1'b1;
    wait_chars(9);
    repeat (30) @(posedge clock_i);
    cmp(17'(got.size()), 17'd9);
    for (int i = 0; i < 9; i++)
      cmp(got[i], {9'h000, 8'h50 + i[7:0]});
  endtask
  initial begin
    fails = 0;
    samples_checked = 0;
    sys_rst_i = 1'b1;
    start = 1'b0;
    len = 8'h00;
    char_ready_i = 1'b1;
    ce = 1'b1;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    s_pair();
    s_half();
    s_full();
    s_zero();
    s_fill();
    s_freeze();
    print_verdict();
  end
endmodule // ucs2_alpha_field_decoder_test
`default_nettype wire
